/* rtl/mode_lock_pkg.sv */
// Package of mode encodings, commands and the command frame width for the mode lock controller.
package mode_lock_pkg;

  // Lifecycle mode as stored in the configuration byte.
  localparam logic [7:0] CFG_OPEN_CODE        = 8'h5A;
  localparam logic [7:0] CFG_LOCKED_CODE      = 8'hA5;
  localparam logic [7:0] CFG_FAILED_CODE      = 8'h3C;
  localparam logic [7:0] CFG_FACTORY_CODE     = 8'hFF;
  localparam logic [7:0] CFG_DELIVERED_VALUE  = CFG_OPEN_CODE;

  // Monitor link command codes.
  localparam logic [3:0] CMD_NONE       = 4'h0;
  localparam logic [3:0] CMD_BREAK      = 4'h1;
  localparam logic [3:0] CMD_RESUME     = 4'h2;
  localparam logic [3:0] CMD_PROG_WRITE = 4'h3;
  localparam logic [3:0] CMD_PROG_READ  = 4'h4;
  localparam logic [3:0] CMD_LOCK       = 4'h5;
  localparam logic [3:0] CMD_UNLOCK     = 4'h6;
  localparam logic [3:0] CMD_TO_OPEN    = 4'h7;

  // Width of a command frame on the monitor serial data line.
  localparam int unsigned CMD_FRAME_BITS = 4;

  typedef enum logic [1:0]
  {
    MODE_OPEN,
    MODE_LOCKED,
    MODE_FAILED_UNLOCK,
    MODE_FACTORY_TEST
  } dev_mode_type;

endpackage

/* rtl/monitor_cmd_rx.sv */
// Serial command receiver for the two-wire monitor link.
`timescale 1ns/1ps
`default_nettype none

module monitor_cmd_rx
  import mode_lock_pkg::*;
#(
  parameter int unsigned FRAME_BITS = CMD_FRAME_BITS
)
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Monitor link pins
  input  wire logic                  monitor_serial_clock_i,
  input  wire logic                  monitor_serial_data_i,
  // Decoded command
  output logic                       cmd_valid_o,
  output logic [FRAME_BITS-1:0]      cmd_code_o
);

  logic [1:0]            sck_sync_ff;
  logic [1:0]            sda_sync_ff;
  logic                  sck_prev_ff;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [$clog2(FRAME_BITS+1)-1:0] count_ff;
  logic                  valid_ff;
  logic [FRAME_BITS-1:0] code_ff;

  wire sck_rise   = sck_sync_ff[1] & ~sck_prev_ff;
  wire frame_done = sck_rise && (count_ff == ($clog2(FRAME_BITS+1))'(FRAME_BITS - 1));
  wire [FRAME_BITS-1:0] nxt_shift = {shift_ff[FRAME_BITS-2:0], sda_sync_ff[1]};

  // Both pins pass two flip-flops; bits are taken MSB first on rising clock edges.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sck_sync_ff <= '0;
      sda_sync_ff <= '0;
      sck_prev_ff <= 1'b0;
      shift_ff    <= '0;
      count_ff    <= '0;
      valid_ff    <= 1'b0;
      code_ff     <= '0;
    end
    else
    begin
      sck_sync_ff <= {sck_sync_ff[0], monitor_serial_clock_i};
      sda_sync_ff <= {sda_sync_ff[0], monitor_serial_data_i};
      sck_prev_ff <= sck_sync_ff[1];
      valid_ff    <= frame_done;
      if (sck_rise)
      begin
        shift_ff <= nxt_shift;
        count_ff <= frame_done ? '0 : count_ff + 1'b1;
      end
      if (frame_done)
      begin
        code_ff <= nxt_shift;
      end
    end
  end

  assign cmd_valid_o = valid_ff;
  assign cmd_code_o  = code_ff;

endmodule // monitor_cmd_rx

`default_nettype wire

/* rtl/device_mode_lock_control.sv */
// Lifecycle mode controller gating debug, program memory access and software break.
//
// Behaviour
// - Mode decoded from stored configuration byte.
// - Config byte changes only via monitor command.
// - Delivered configuration encodes open mode.
// - Open mode allows full command set.
// - Open mode break command halts application.
// - Halt holds until resume, reset or exit from open mode.
// - Locked mode blocks access and debug.
// - Unlock erases memory, then enters open.
// - Failed erase leaves device failed_unlock_mode.
// - Failed_unlock_mode mode held during erase sequence.
// - Failed_unlock_mode accepts a new unlock command to retry.
// - Factory test mode never re-entered.
`timescale 1ns/1ps
`default_nettype none

module device_mode_lock_control
  import mode_lock_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  // Monitor link pins
  input  wire logic                      monitor_serial_clock_i,
  input  wire logic                      monitor_serial_data_i,
  // Non-volatile configuration byte
  input  wire logic [7:0]                cfg_byte_i,
  input  wire logic                      cfg_valid_i,
  output logic                           cfg_write_o,
  output logic [7:0]                     cfg_wdata_o,
  // User (application) write attempt to the configuration byte
  input  wire logic                      user_cfg_write_i,
  // Program memory erase engine
  output logic                           erase_start_o,
  input  wire logic                      erase_done_i,
  input  wire logic                      erase_ok_i,
  // Status and gates
  output mode_lock_pkg::dev_mode_type    mode_o,
  output logic                           debug_enable_o,
  output logic                           prog_read_allow_o,
  output logic                           prog_write_allow_o,
  output logic                           cpu_halt_o,
  output logic                           user_write_refused_o,
  output logic                           cmd_prog_write_o,
  output logic                           cmd_prog_read_o
);

  import mode_lock_pkg::*;

  typedef enum logic [1:0]
  {
    SEQ_IDLE,
    SEQ_MARK,
    SEQ_ERASE,
    SEQ_COMMIT
  } seq_state_type;

  ////////////////////////////////////////////////////////////////////////////

  logic                  cmd_valid;
  logic [CMD_FRAME_BITS-1:0] cmd_code;

  monitor_cmd_rx #(
    .FRAME_BITS (CMD_FRAME_BITS)
  ) u_cmd_rx (
    .clk_i                  (clk_i),
    .reset_i                (reset_i),
    .monitor_serial_clock_i (monitor_serial_clock_i),
    .monitor_serial_data_i  (monitor_serial_data_i),
    .cmd_valid_o            (cmd_valid),
    .cmd_code_o             (cmd_code)
  );

  ////////////////////////////////////////////////////////////////////////////

  seq_state_type state_ff;
  logic          halt_ff;
  logic          cfg_write_ff;
  logic [7:0]    cfg_wdata_ff;
  logic          erase_start_ff;
  logic          refused_ff;
  logic          pwrite_ff;
  logic          pread_ff;

  dev_mode_type  stored_mode;

  // Stored byte decoded to a mode; anything unknown reads as locked.
  always_comb
  begin
    case (cfg_byte_i)
      CFG_OPEN_CODE:    stored_mode = MODE_OPEN;
      CFG_FAILED_CODE:  stored_mode = MODE_FAILED_UNLOCK;
      CFG_FACTORY_CODE: stored_mode = MODE_FACTORY_TEST;
      default:          stored_mode = MODE_LOCKED;
    endcase
  end

  // Until the byte is loaded the device stays closed.
  wire dev_mode_type cur_mode = cfg_valid_i ? stored_mode : MODE_LOCKED;

  wire is_open    = (cur_mode == MODE_OPEN);
  wire is_factory = (cur_mode == MODE_FACTORY_TEST);
  wire is_locked  = (cur_mode == MODE_LOCKED);
  wire is_failed  = (cur_mode == MODE_FAILED_UNLOCK);
  wire debug_ok   = (is_open || is_factory) && (state_ff == SEQ_IDLE);

  wire cmd_break   = cmd_valid && (cmd_code == CMD_BREAK) && is_open;
  wire cmd_resume  = cmd_valid && (cmd_code == CMD_RESUME);
  wire cmd_lock    = cmd_valid && (cmd_code == CMD_LOCK) && debug_ok;
  wire cmd_to_open = cmd_valid && (cmd_code == CMD_TO_OPEN) && is_factory
                     && (state_ff == SEQ_IDLE);
  wire cmd_unlock  = cmd_valid && (cmd_code == CMD_UNLOCK) && (is_locked || is_failed)
                     && (state_ff == SEQ_IDLE);

  // Leaving factory test writes the open code, or the locked code on a lock command, and no path writes the factory code back.
  wire       idle_write = cmd_lock || cmd_to_open;
  wire [7:0] idle_wdata = cmd_lock ? CFG_LOCKED_CODE : CFG_OPEN_CODE;

  // Erase sequence: mark failed_unlock_mode, erase, then commit open only on success.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_ff       <= SEQ_IDLE;
      cfg_write_ff   <= 1'b0;
      cfg_wdata_ff   <= CFG_DELIVERED_VALUE;
      erase_start_ff <= 1'b0;
    end
    else
    begin
      cfg_write_ff   <= 1'b0;
      erase_start_ff <= 1'b0;
      case (state_ff)
        SEQ_IDLE:
        begin
          if (cmd_unlock)
          begin
            state_ff     <= SEQ_MARK;
            cfg_write_ff <= 1'b1;
            cfg_wdata_ff <= CFG_FAILED_CODE;
          end
          else if (idle_write)
          begin
            cfg_write_ff <= 1'b1;
            cfg_wdata_ff <= idle_wdata;
          end
        end
        SEQ_MARK:
        begin
          state_ff       <= SEQ_ERASE;
          erase_start_ff <= 1'b1;
        end
        SEQ_ERASE:
        begin
          if (erase_done_i)
          begin
            if (erase_ok_i)
            begin
              state_ff     <= SEQ_COMMIT;
              cfg_write_ff <= 1'b1;
              cfg_wdata_ff <= CFG_OPEN_CODE;
            end
            else
            begin
              state_ff <= SEQ_IDLE;
            end
          end
        end
        SEQ_COMMIT:
        begin
          state_ff <= SEQ_IDLE;
        end
        default:
        begin
          state_ff <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Software break holds until resume or reset; leaving open mode also frees it.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      halt_ff <= 1'b0;
    end
    else if (cmd_break)
    begin
      halt_ff <= 1'b1;
    end
    else if (cmd_resume || !is_open)
    begin
      halt_ff <= 1'b0;
    end
  end

  // User writes are refused and reported; program commands pass only in open or factory test mode with the sequencer idle.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      refused_ff <= 1'b0;
      pwrite_ff  <= 1'b0;
      pread_ff   <= 1'b0;
    end
    else
    begin
      refused_ff <= user_cfg_write_i;
      pwrite_ff  <= cmd_valid && (cmd_code == CMD_PROG_WRITE) && debug_ok;
      pread_ff   <= cmd_valid && (cmd_code == CMD_PROG_READ) && debug_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign mode_o               = cur_mode;
  assign debug_enable_o       = debug_ok;
  assign prog_read_allow_o    = debug_ok;
  assign prog_write_allow_o   = debug_ok;
  assign cpu_halt_o           = halt_ff;
  assign cfg_write_o          = cfg_write_ff;
  assign cfg_wdata_o          = cfg_wdata_ff;
  assign erase_start_o        = erase_start_ff;
  assign user_write_refused_o = refused_ff;
  assign cmd_prog_write_o     = pwrite_ff;
  assign cmd_prog_read_o      = pread_ff;

endmodule // device_mode_lock_control

`default_nettype wire

/* bench/mode_lock_chk.sv */
// Assertion checker for the mode lock controller ports.
`timescale 1ns/1ps
`default_nettype none
module mode_lock_chk
  import mode_lock_pkg::*;
(
  // Clock, reset and inputs
  input wire logic         clk_i,
  input wire logic         reset_i,
  input wire logic [7:0]   cfg_byte_i,
  input wire logic         cfg_valid_i,
  input wire logic         user_cfg_write_i,
  input wire logic         erase_done_i,
  input wire logic         erase_ok_i,
  // Outputs
  input wire logic         cfg_write_o,
  input wire logic [7:0]   cfg_wdata_o,
  input wire logic         erase_start_o,
  input wire dev_mode_type mode_o,
  input wire logic         debug_enable_o,
  input wire logic         prog_read_allow_o,
  input wire logic         cpu_halt_o,
  input wire logic         user_write_refused_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire known_code = cfg_byte_i inside {CFG_OPEN_CODE, CFG_LOCKED_CODE, CFG_FAILED_CODE,
                                       CFG_FACTORY_CODE};
  sequence unlock_begin;
    cfg_write_o && cfg_wdata_o == CFG_FAILED_CODE;
  endsequence
  sequence erase_pass;
    erase_done_i && erase_ok_i && mode_o == MODE_FAILED_UNLOCK;
  endsequence
  chk_user_refused: assert property (
    user_cfg_write_i |=> user_write_refused_o && !cfg_write_o) else $error("user write passed");
  chk_open_decode: assert property (
    cfg_valid_i && cfg_byte_i == CFG_OPEN_CODE |-> mode_o == MODE_OPEN) else $error("bad decode");
  chk_undef_locked: assert property (
    !cfg_valid_i || !known_code |-> mode_o == MODE_LOCKED) else $error("undefined not locked");
  chk_locked_gates: assert property (
    mode_o == MODE_LOCKED |-> !debug_enable_o && !prog_read_allow_o) else $error("gates open");
  chk_erase_follows: assert property (
    unlock_begin |=> erase_start_o && !cfg_write_o) else $error("erase did not start");
  chk_open_after: assert property (
    erase_pass |=> cfg_write_o && cfg_wdata_o == CFG_OPEN_CODE) else $error("no return to open");
  chk_fail_stays: assert property (
    erase_done_i && !erase_ok_i |=> !cfg_write_o [*3]) else $error("failed erase left mode");
  chk_halt_open: assert property (
    $rose(cpu_halt_o) |-> $past(mode_o) == MODE_OPEN) else $error("halt outside open mode");
  chk_halt_exit: assert property (
    cpu_halt_o && mode_o != MODE_OPEN |=> !cpu_halt_o) else $error("halt kept after lock");
  chk_no_factory: assert property (
    cfg_write_o |-> cfg_wdata_o != CFG_FACTORY_CODE) else $error("factory code written");
endmodule // mode_lock_chk
bind device_mode_lock_control mode_lock_chk chk (.*);
`default_nettype wire

/* bench/debug_host_model.sv */
// Debug host model that sends command frames on the monitor link.
`timescale 1ns/1ps
`default_nettype none
module debug_host_model
(
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      sdata_o
);
  initial
  begin
    sclk_o = 1'b0;
    sdata_o = 1'b1;
  end
  // Clock rests low between frames; data then shows the inverse of the last bit.
  task automatic send(input logic [3:0] code);
    for (int i = 3; i >= 0; i--)
    begin
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      sdata_o <= code[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
    end
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b0;
    sdata_o <= ~code[0];
  endtask
endmodule // debug_host_model
`default_nettype wire

/* bench/test_device_mode_lock_control.sv */
// Self-checking testbench for the mode lock controller.
`timescale 1ns/1ps
`default_nettype none
module test_device_mode_lock_control;
  import mode_lock_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, cfg_valid_i = 1'b1, user_cfg_write_i = 1'b0;
  logic erase_done_i = 1'b0, erase_ok_i = 1'b0, erase_pass = 1'b1;
  logic [7:0] cfg_byte_i = CFG_DELIVERED_VALUE, cfg_wdata_o;
  logic [7:0] n_wr = 0, n_pw = 0, n_pr = 0, n_ref = 0, n_es = 0;
  wire logic sclk, sdata, cfg_write_o, erase_start_o, debug_enable_o, prog_read_allow_o;
  wire logic prog_write_allow_o, cpu_halt_o, user_write_refused_o, pw, pr;
  dev_mode_type mode_o;
  int errors = 0, samples_checked = 0;
  always #2.5 clk_i = ~clk_i;
  debug_host_model host (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata));
  device_mode_lock_control dut (.clk_i(clk_i), .reset_i(reset_i),
    .monitor_serial_clock_i(sclk), .monitor_serial_data_i(sdata), .cfg_byte_i(cfg_byte_i),
    .cfg_valid_i(cfg_valid_i), .cfg_write_o(cfg_write_o), .cfg_wdata_o(cfg_wdata_o),
    .user_cfg_write_i(user_cfg_write_i), .erase_start_o(erase_start_o),
    .erase_done_i(erase_done_i), .erase_ok_i(erase_ok_i), .mode_o(mode_o),
    .debug_enable_o(debug_enable_o), .prog_read_allow_o(prog_read_allow_o),
    .prog_write_allow_o(prog_write_allow_o), .cpu_halt_o(cpu_halt_o),
    .user_write_refused_o(user_write_refused_o), .cmd_prog_write_o(pw), .cmd_prog_read_o(pr));
  // Stored configuration byte, erase engine and pulse counters.
  always @(posedge clk_i)
  begin
    n_pw <= n_pw + (pw === 1'b1);
    n_pr <= n_pr + (pr === 1'b1);
    n_ref <= n_ref + (user_write_refused_o === 1'b1);
    n_wr <= n_wr + (cfg_write_o === 1'b1);
    if (cfg_write_o === 1'b1) cfg_byte_i <= cfg_wdata_o;
    erase_done_i <= 1'b0;
    if (erase_start_o === 1'b1)
    begin
      n_es <= n_es + 1;
      repeat (20) @(posedge clk_i);
      erase_done_i <= 1'b1;
      erase_ok_i <= erase_pass;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] c);
    host.send(c);
    repeat (12) @(posedge clk_i);
  endtask
  task automatic t_open;
    check(mode_o, MODE_OPEN);
    @(posedge clk_i) user_cfg_write_i <= 1'b1;
    @(posedge clk_i) user_cfg_write_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(n_ref, 1);
    check({n_wr, cfg_byte_i}, {8'h00, CFG_OPEN_CODE});
    check({debug_enable_o, prog_write_allow_o}, 2'b11);
    cmd(CMD_PROG_WRITE);
    cmd(CMD_PROG_READ);
    check({n_pw, n_pr}, {8'h01, 8'h01});
    $display("Test open mode finished");
  endtask
  task automatic t_break;
    cmd(CMD_BREAK);
    check(cpu_halt_o, 1);
    repeat (30) @(posedge clk_i);
    check(cpu_halt_o, 1);
    cmd(CMD_RESUME);
    check(cpu_halt_o, 0);
    cmd(CMD_BREAK);
    @(posedge clk_i) reset_i <= 1'b1;
    repeat (2) @(posedge clk_i) reset_i <= 1'b0;
    check(cpu_halt_o, 0);
    $display("Test break finished");
  endtask
  task automatic t_lock;
    cmd(CMD_BREAK);
    check(cpu_halt_o, 1);
    cmd(CMD_LOCK);
    check({cfg_byte_i, mode_o}, {CFG_LOCKED_CODE, MODE_LOCKED});
    check({debug_enable_o, prog_read_allow_o, prog_write_allow_o}, 3'b000);
    check(cpu_halt_o, 0);
    cmd(CMD_BREAK);
    cmd(CMD_PROG_READ);
    check({cpu_halt_o, n_pr}, {1'b0, 8'h01});
    $display("Test lock finished");
  endtask
  task automatic t_unlock;
    erase_pass = 1'b0;
    cmd(CMD_UNLOCK);
    check(mode_o, MODE_FAILED_UNLOCK);
    repeat (25) @(posedge clk_i);
    check(mode_o, MODE_FAILED_UNLOCK);
    erase_pass = 1'b1;
    cmd(CMD_UNLOCK);
    repeat (25) @(posedge clk_i);
    check({cfg_byte_i, mode_o}, {CFG_OPEN_CODE, MODE_OPEN});
    check(n_es, 2);
    $display("Test unlock finished");
  endtask
  task automatic t_cfg;
    logic [7:0] wr_before;
    @(posedge clk_i) cfg_byte_i <= CFG_FACTORY_CODE;
    @(posedge clk_i);
    check(mode_o, MODE_FACTORY_TEST);
    cmd(CMD_TO_OPEN);
    check(cfg_byte_i, CFG_OPEN_CODE);
    wr_before = n_wr;
    cmd(CMD_TO_OPEN);
    check(n_wr, wr_before);
    check(mode_o, MODE_OPEN);
    @(posedge clk_i) cfg_byte_i <= 8'h00;
    @(posedge clk_i);
    check(mode_o, MODE_LOCKED);
    @(posedge clk_i) cfg_valid_i <= 1'b0;
    cfg_byte_i <= CFG_OPEN_CODE;
    @(posedge clk_i);
    check(mode_o, MODE_LOCKED);
    $display("Test decode finished");
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_open();
    t_break();
    t_lock();
    t_unlock();
    t_cfg();
    tally_and_finish();
  end
  initial
  begin
    #40000;
    errors++;
    tally_and_finish();
  end
endmodule // test_device_mode_lock_control
`default_nettype wire
